// *** burst_master.sv ***
// External bus master issuing non-wrapping bursts of up to eight words.
// Assumes slave steps low address bits and answers each beat with acknowledge.
`timescale 1ns/10ps
`default_nettype none
`include "burst_defines.svh"
module burst_master (
  input wire logic ref_clk,
  input wire logic nrst,
  // Request side
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [`ADDR_W-1:0] reqAddr,
  input wire logic [`ATTR_W-1:0] reqAttr,
  input wire logic [`LEN_W-1:0] reqLen,
  input wire logic wrValid,
  input wire logic [`DATA_W-1:0] wrData,
  output logic wrReady,
  output logic rdValid,
  output logic [`DATA_W-1:0] rdData,
  input wire logic rdReady,
  output logic xferDone,
  // Configuration levels
  input wire logic burstEnable,
  input wire logic shortSetupOption,
  input wire logic blockOf8,
  // External bus
  output logic busStart,
  output logic busBurst,
  output logic busWrite,
  output logic [`ADDR_W-1:0] busAddr,
  output logic [`ATTR_W-1:0] busAttr,
  output logic [`DATA_W-1:0] busDataOut,
  output logic busDataOe,
  input wire logic [`DATA_W-1:0] busDataIn,
  input wire logic transferAcknowledge
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic taMeta_reg, taSync_reg;
  logic [`DATA_W-1:0] dinMeta_reg, dinSync_reg;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      taMeta_reg <= 1'b0;
      taSync_reg <= 1'b0;
      dinMeta_reg <= '0;
      dinSync_reg <= '0;
    end else begin
      taMeta_reg <= transferAcknowledge;
      taSync_reg <= taMeta_reg;
      dinMeta_reg <= busDataIn;
      dinSync_reg <= dinMeta_reg;
    end
  end

  // ************************************************************
  // Read FIFO
  // ************************************************************
  stream_if fin ();
  stream_if fout ();
  word_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .PW(`FIFO_PTR_W)) rdFifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .inS(fin),
    .outS(fout)
  );

  // Words left to the aligned boundary from a start word
  function automatic logic [`LEN_W-1:0] toBoundary(input logic [`ADDR_W-1:0] a,
                                                   input logic b8);
    logic [2:0] w;
    w = a[`WORD_LSB+2:`WORD_LSB];
    if (b8) toBoundary = `MAX_BEATS - {1'b0, w & `BLK8_MASK};
    else toBoundary = `LEN_W'(3'h4 - (w & `BLK4_MASK));
  endfunction : toBoundary

  function automatic logic [`LEN_W-1:0] minLen(input logic [`LEN_W-1:0] a,
                                               input logic [`LEN_W-1:0] b);
    minLen = (a < b) ? a : b;
  endfunction : minLen

  // ************************************************************
  // Bus sequencer
  // ************************************************************
  burst_pkg::bus_state_t st_reg, st_next;
  logic [`LEN_W-1:0] left_reg, left_next;   // words still owed overall
  logic [`LEN_W-1:0] beats_reg, beats_next; // beats left in this cycle
  logic [`ADDR_W-1:0] addr_reg, addr_next;
  logic [`ATTR_W-1:0] attr_reg, attr_next;
  logic wr_reg, wr_next, burst_reg, burst_next, start_reg, start_next;
  logic oe_reg, oe_next, done_reg, done_next, wrRdy_reg, wrRdy_next;
  logic [`DATA_W-1:0] dout_reg, dout_next;
  logic [`LEN_W-1:0] len_reg, len_next;     // beats granted to this cycle
  logic [`FIFO_PTR_W:0] occ_reg, occ_next;  // words held in the read FIFO
  logic reqRdy_reg, reqRdy_next, rdV_reg, rdV_next;
  logic [`DATA_W-1:0] rdD_reg, rdD_next;
  logic [`LEN_W-1:0] chunk;
  logic roomOk;

  always_comb begin
    st_next = st_reg;
    left_next = left_reg;
    beats_next = beats_reg;
    addr_next = addr_reg;
    attr_next = attr_reg;
    wr_next = wr_reg;
    burst_next = burst_reg;
    start_next = 1'b0;
    oe_next = oe_reg;
    done_next = 1'b0;
    wrRdy_next = 1'b0;
    dout_next = dout_reg;
    len_next = len_reg;
    fin.valid = 1'b0;
    fin.data = dinSync_reg;
    chunk = burstEnable ? minLen(left_reg, toBoundary(addr_reg, blockOf8))
                        : `LEN_W'(1);
    // Reads need the FIFO to hold the whole cycle, so bus never stalls mid-burst
    roomOk = wr_reg ||
             (({1'b0, occ_reg} + {1'b0, chunk}) <= (`FIFO_PTR_W + 2)'(`FIFO_DEPTH));
    case (st_reg)
      burst_pkg::ST_IDLE: begin
        if (reqValid && reqRdy_reg && reqLen != '0) begin
          addr_next = reqAddr;
          attr_next = reqAttr;
          wr_next = reqWrite;
          left_next = minLen(reqLen, `MAX_BEATS);
          st_next = shortSetupOption ? burst_pkg::ST_SETUP : burst_pkg::ST_ADDR;
        end
      end
      burst_pkg::ST_SETUP: begin
        st_next = burst_pkg::ST_ADDR;
      end
      burst_pkg::ST_ADDR: begin
        if (roomOk && (!wr_reg || wrValid)) begin
          beats_next = chunk;
          len_next = chunk;
          burst_next = chunk > `LEN_W'(1);
          start_next = 1'b1;
          oe_next = wr_reg;
          dout_next = wrData;
          wrRdy_next = wr_reg;
          st_next = burst_pkg::ST_BEAT;
        end
      end
      burst_pkg::ST_BEAT: begin
        if (taSync_reg) begin
          fin.valid = !wr_reg;
          beats_next = beats_reg - 1'b1;
          left_next = left_reg - 1'b1;
          // Address held here; slave steps bits 2..4 itself
          if (beats_reg == `LEN_W'(1)) begin
            // Next address phase starts past every word of this cycle
            addr_next = addr_reg + (`ADDR_W'(len_reg) << `WORD_LSB);
            oe_next = 1'b0;
            burst_next = 1'b0;
            st_next = burst_pkg::ST_DONE;
          end else if (wr_reg) begin
            dout_next = wrData;
            wrRdy_next = 1'b1;
          end
        end
      end
      burst_pkg::ST_DONE: begin
        // Release bus; next independent address phase if words remain
        if (left_reg == '0) begin
          done_next = 1'b1;
          st_next = burst_pkg::ST_IDLE;
        end else begin
          st_next = burst_pkg::ST_ADDR;
        end
      end
      default: st_next = burst_pkg::ST_IDLE;
    endcase
  end

  // ************************************************************
  // Read output stage and FIFO occupancy
  // ************************************************************
  // Output word holds until the consumer takes it
  always_comb begin
    fout.ready = !rdV_reg || rdReady;
    rdV_next = rdV_reg;
    rdD_next = rdD_reg;
    if (fout.ready) begin
      rdV_next = fout.valid;
      rdD_next = fout.data;
    end
    occ_next = occ_reg + (`FIFO_PTR_W + 1)'(fin.valid && fin.ready)
               - (`FIFO_PTR_W + 1)'(fout.valid && fout.ready);
    reqRdy_next = (st_next == burst_pkg::ST_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg <= burst_pkg::ST_IDLE;
      left_reg <= '0;
      beats_reg <= '0;
      addr_reg <= '0;
      attr_reg <= '0;
      wr_reg <= 1'b0;
      burst_reg <= 1'b0;
      start_reg <= 1'b0;
      oe_reg <= 1'b0;
      done_reg <= 1'b0;
      wrRdy_reg <= 1'b0;
      dout_reg <= '0;
      len_reg <= '0;
      occ_reg <= '0;
    end else begin
      st_reg <= st_next;
      left_reg <= left_next;
      beats_reg <= beats_next;
      addr_reg <= addr_next;
      attr_reg <= attr_next;
      wr_reg <= wr_next;
      burst_reg <= burst_next;
      start_reg <= start_next;
      oe_reg <= oe_next;
      done_reg <= done_next;
      wrRdy_reg <= wrRdy_next;
      dout_reg <= dout_next;
      len_reg <= len_next;
      occ_reg <= occ_next;
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reqRdy_reg <= 1'b0;
      rdV_reg <= 1'b0;
      rdD_reg <= '0;
    end else begin
      reqRdy_reg <= reqRdy_next;
      rdV_reg <= rdV_next;
      rdD_reg <= rdD_next;
    end
  end

  assign reqReady = reqRdy_reg;
  assign rdValid = rdV_reg;
  assign rdData = rdD_reg;
  assign wrReady = wrRdy_reg;
  assign xferDone = done_reg;
  assign busStart = start_reg;
  assign busBurst = burst_reg;
  assign busWrite = wr_reg;
  assign busAddr = addr_reg;
  assign busAttr = attr_reg;
  assign busDataOut = dout_reg;
  assign busDataOe = oe_reg;
endmodule : burst_master
`default_nettype wire

// *** burst_defines.svh ***
// Constants for the external bus burst master.
// Assumes one 100 MHz clock and a byte-addressed external slave with 4-byte words.
// What this block does
// - Burst moves up to eight words
// - Burst stops at aligned boundary, never wraps
// - Bursts only when burst enable set
// - Start address selects word in block
// - Address and attributes stable whole burst
// - Short setup adds one initial clock
`ifndef BURST_DEFINES_SVH
`define BURST_DEFINES_SVH
`define ADDR_W 32
`define DATA_W 32
`define ATTR_W 4
`define LEN_W 4
`define MAX_BEATS 4'h8
`define FIFO_DEPTH 8
`define FIFO_PTR_W 3
`define WORD_LSB 2
`define BLK4_MASK 3'h3
`define BLK8_MASK 3'h7
`define SETUP_CYCLES 2'h1
`endif

// *** burst_pkg.sv ***
// Types for the external bus burst master.
// Assumes burst_defines.svh is included first.
`default_nettype none
`include "burst_defines.svh"
package burst_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_SETUP = 5'b0_0010,
    ST_ADDR = 5'b0_0100,
    ST_BEAT = 5'b0_1000,
    ST_DONE = 5'b1_0000
  } bus_state_t;
endpackage : burst_pkg
`default_nettype wire

// *** stream_if.sv ***
// Valid/ready word stream between the master and its FIFO.
// Assumes a single clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "burst_defines.svh"
interface stream_if;
  logic valid;
  logic ready;
  logic [`DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// *** word_fifo.sv ***
// Parameterised flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "burst_defines.svh"
module word_fifo #(
  parameter int WIDTH = `DATA_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int PW = `FIFO_PTR_W
) (
  input wire logic ref_clk,
  input wire logic nrst,
  stream_if.snk inS,
  stream_if.src outS
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic push, pop;

  always_comb begin
    push = inS.valid && inS.ready;
    pop = outS.valid && outS.ready;
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push) begin
      mem_next[wr_reg] = inS.data;
      wr_next = wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = rd_reg + 1'b1;
    end
    cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
  end

  assign inS.ready = cnt_reg != (PW+1)'(DEPTH);
  assign outS.valid = cnt_reg != '0;
  assign outS.data = mem_reg[rd_reg];

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end
endmodule : word_fifo
`default_nettype wire

// *** burst_master_checker.sv ***
// Concurrent checks on the burst master ports.
// Assumes one clock and a bind onto burst_master.
`timescale 1ns/10ps
`default_nettype none
`include "burst_defines.svh"
module burst_master_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [`LEN_W-1:0] reqLen,
  input wire logic xferDone,
  input wire logic burstEnable,
  input wire logic shortSetupOption,
  input wire logic blockOf8,
  input wire logic busStart,
  input wire logic busBurst,
  input wire logic busWrite,
  input wire logic [`ADDR_W-1:0] busAddr,
  input wire logic [`ATTR_W-1:0] busAttr,
  input wire logic busDataOe,
  input wire logic transferAcknowledge
);
  // ***
  // Beat counting
  // ***
  logic [3:0] beat_reg;
  logic [3:0] beat_next;
  logic [3:0] bnd;
  logic take;
  assign take = reqValid && reqReady && reqLen != 4'h0;
  assign bnd = blockOf8 ? 4'h8 - {1'b0, busAddr[4:2]} : 4'h4 - {2'h0, busAddr[3:2]};
  always_comb begin
    beat_next = beat_reg;
    if (busStart) beat_next = 4'h0;
    else if (busBurst && transferAcknowledge) beat_next = beat_reg + 4'h1;
  end
  always_ff @(posedge ref_clk) beat_reg <= nrst ? beat_next : 4'h0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_attr_stable: assert property (
    busBurst && $past(busBurst) && !busStart |-> $stable(busAddr) && $stable(busAttr)
    && $stable(busWrite)) else $error("attributes moved in burst");
  a_burst_gated: assert property (
    busStart && !burstEnable |-> !busBurst) else $error("burst while disabled");
  a_stop_bound: assert property (
    busBurst && beat_reg == bnd |-> ##[1:4] !busBurst) else $error("burst past boundary");
  a_ack_needed: assert property (
    $fell(busBurst) |-> beat_reg != 4'h0) else $error("burst ended without ack");
  a_setup_plain: assert property (
    take && !shortSetupOption |-> ##[1:2] busStart) else $error("late address phase");
  a_setup_extra: assert property (
    take && shortSetupOption |-> ##1 !busStart ##[1:2] busStart) else $error("no extra clock");
  a_idle_free: assert property (
    reqReady |-> !busBurst && !busStart) else $error("bus held while idle");
  a_oe_write: assert property (
    busDataOe |-> busWrite) else $error("driving data on read");
  a_done_idle: assert property (
    xferDone |-> !busBurst) else $error("done inside burst");
  c_full: cover property (busBurst && beat_reg == 4'h8);
  c_single: cover property (busStart && !busBurst);
  c_sst: cover property (take && shortSetupOption);
endmodule : burst_master_checker
bind burst_master burst_master_checker chk (
  .ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady),
  .reqLen(reqLen), .xferDone(xferDone), .burstEnable(burstEnable),
  .shortSetupOption(shortSetupOption), .blockOf8(blockOf8), .busStart(busStart),
  .busBurst(busBurst), .busWrite(busWrite), .busAddr(busAddr), .busAttr(busAttr),
  .busDataOe(busDataOe), .transferAcknowledge(transferAcknowledge)
);
`default_nettype wire

// *** bus_slave_model.sv ***
// Word slave answering each beat with acknowledge.
// Assumes master drops busBurst within four clocks of the last ack.
`timescale 1ns/10ps
`default_nettype none
`include "burst_defines.svh"
module bus_slave_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic busStart,
  input wire logic busBurst,
  input wire logic busWrite,
  input wire logic [`ADDR_W-1:0] busAddr,
  input wire logic [`DATA_W-1:0] busDataOut,
  output var logic [`DATA_W-1:0] busDataIn,
  output var logic transferAcknowledge
);
  logic [`ADDR_W-1:0] adr;
  logic act;
  logic first;
  logic [3:0] cnt;
  logic [`DATA_W-1:0] wrLog[$];
  initial begin
    busDataIn = '0;
    transferAcknowledge = 1'b0;
  end
  always @(posedge ref_clk) begin
    transferAcknowledge <= 1'b0;
    // Released bus toggles so no stale word looks valid
    busDataIn <= ~busDataIn;
    if (!nrst) act <= 1'b0;
    else if (busStart) begin
      act <= 1'b1;
      first <= 1'b1;
      adr <= busAddr;
      cnt <= slow ? 4'h9 : 4'h4;
    end else if (act && cnt != 4'h0) cnt <= cnt - 4'h1;
    else if (act && (first || busBurst)) begin
      transferAcknowledge <= 1'b1;
      busDataIn <= adr;
      if (busWrite) wrLog.push_back(busDataOut);
      adr <= adr + 32'h4;
      first <= 1'b0;
      act <= busBurst;
      cnt <= slow ? 4'h9 : 4'h4;
    end else act <= 1'b0;
  end
endmodule : bus_slave_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the burst master.
// Assumes the slave model answers on the external bus.
`timescale 1ns/10ps
`default_nettype none
`include "burst_defines.svh"
module testbench;
  logic ref_clk, nrst, reqValid, reqWrite, wrValid, rdReady, slow;
  logic burstEnable, shortSetupOption, blockOf8, reqReady, wrReady, rdValid;
  logic xferDone, busStart, busBurst, busWrite, busDataOe, transferAcknowledge;
  logic [31:0] reqAddr, wrData, rdData, busAddr, busDataOut, busDataIn, wrIdx, firstAddr;
  logic [3:0] reqAttr, reqLen, busAttr;
  int n_fail, n_checks, starts, l0, l1;
  logic [31:0] rdQ[$];
  burst_master uut (
    .ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqAttr(reqAttr), .reqLen(reqLen),
    .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady), .rdValid(rdValid),
    .rdData(rdData), .rdReady(rdReady), .xferDone(xferDone), .burstEnable(burstEnable),
    .shortSetupOption(shortSetupOption), .blockOf8(blockOf8), .busStart(busStart),
    .busBurst(busBurst), .busWrite(busWrite), .busAddr(busAddr), .busAttr(busAttr),
    .busDataOut(busDataOut), .busDataOe(busDataOe), .busDataIn(busDataIn),
    .transferAcknowledge(transferAcknowledge)
  );
  bus_slave_model slv (
    .ref_clk(ref_clk), .nrst(nrst), .slow(slow), .busStart(busStart), .busBurst(busBurst),
    .busWrite(busWrite), .busAddr(busAddr), .busDataOut(busDataOut), .busDataIn(busDataIn),
    .transferAcknowledge(transferAcknowledge)
  );
  assign wrData = 32'hA5A5_0000 + wrIdx;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (busStart && starts == 0) firstAddr <= busAddr;
    if (busStart) starts <= starts + 1;
    if (rdValid && rdReady) rdQ.push_back(rdData);
    if (wrValid && wrReady) wrIdx <= wrIdx + 32'h1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task run(input logic w, input logic [31:0] a, input logic [3:0] n, output int l);
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqLen = n;
    wrValid = w;
    starts = 0;
    wrIdx = 0;
    l = 0;
    rdQ.delete();
    slv.wrLog.delete();
    @(posedge ref_clk);
    #1 reqValid = 1'b0;
    while (!busStart && l < 20) begin
      @(posedge ref_clk);
      #1 l++;
    end
    for (int i = 0; i < 400 && !xferDone; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(xferDone, 1);
    chk(firstAddr, a);
    chk(reqReady, 1'b1);
    wrValid = 1'b0;
  endtask : run
  task drain(input logic [31:0] a, input int n);
    rdReady = 1'b1;
    repeat (14) @(posedge ref_clk);
    #1 rdReady = 1'b0;
    chk(rdQ.size(), n);
    for (int i = 0; i < n; i++) chk(rdQ[i], a + 4 * i);
  endtask : drain
  task t_full;
    burstEnable = 1'b1;
    blockOf8 = 1'b1;
    run(1'b0, 32'h0000_1000, 4'h8, l0);
    chk(starts, 1);
    drain(32'h0000_1000, 8);
    $display("t_full done");
  endtask : t_full
  task t_bound;
    blockOf8 = 1'b0;
    run(1'b0, 32'h0000_2008, 4'h6, l0);
    chk(starts, 2);
    drain(32'h0000_2008, 6);
    $display("t_bound done");
  endtask : t_bound
  task t_single;
    burstEnable = 1'b0;
    slow = 1'b1;
    run(1'b0, 32'h0000_3004, 4'h3, l0);
    chk(starts, 3);
    drain(32'h0000_3004, 3);
    slow = 1'b0;
    $display("t_single done");
  endtask : t_single
  task t_write;
    burstEnable = 1'b1;
    blockOf8 = 1'b1;
    reqAttr = 4'hA;
    run(1'b1, 32'h0000_4010, 4'h4, l0);
    chk(busAttr, 4'hA);
    chk(slv.wrLog.size(), 4);
    for (int i = 0; i < 4; i++) chk(slv.wrLog[i], 32'hA5A5_0000 + i);
    $display("t_write done");
  endtask : t_write
  task t_sst;
    run(1'b0, 32'h0000_5000, 4'h1, l0);
    drain(32'h0000_5000, 1);
    shortSetupOption = 1'b1;
    run(1'b0, 32'h0000_5000, 4'h1, l1);
    drain(32'h0000_5000, 1);
    chk(l1, l0 + 1);
    shortSetupOption = 1'b0;
    $display("t_sst done");
  endtask : t_sst
  task end_of_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    {reqValid, reqWrite, wrValid, rdReady, slow, nrst} = '0;
    {burstEnable, shortSetupOption, blockOf8} = '0;
    {reqAddr, wrIdx, reqLen, reqAttr} = {64'h0, 8'h05};
    {n_fail, n_checks, starts} = '0;
    repeat (2) @(posedge ref_clk);
    #1 nrst = 1'b1;
    @(posedge ref_clk);
    #1;
    t_full;
    t_bound;
    t_single;
    t_write;
    t_sst;
    end_of_test;
  end
  // Whole run is well under two thousand cycles
  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
